// ===== verification/dcc_compare_assertions.sv
module dcc_compare_chk (
  input wire mclk_in, // clock
  input wire nrst_in, // reset, active low
  input wire [3:0] addr_in, // address
  input wire [15:0] wr_data_in, // write data
  input wire wr_in, // write strobe
  input wire rd_in, // read strobe
  input wire [15:0] rd_data_out, // read data
  input wire [3:0] pwm_hi_out, // high side
  input wire [3:0] pwm_lo_out, // low side
  input wire period_event_out // period pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [11:0] per_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // ----
  // period shadow, so reads are tied to the last write
  // ----
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) per_q <= 12'hFFF;
    else if (wr_in && addr_in == 4'h1) per_q <= wr_data_in[11:0];
  end
  chk_period_read: assert property (rd_in && addr_in == 4'h1 |=> rd_data_out == {4'h0, per_q})
    else $error("period readback wrong");
  chk_unmapped_zero: assert property (rd_in && addr_in[3:1] == 3'h3 |=> rd_data_out == 16'h0000)
    else $error("unmapped read not zero");
  chk_read_hold: assert property (!rd_in |=> $stable(rd_data_out))
    else $error("read data moved without a read");
  chk_duty_hi_bits: assert property (rd_in && addr_in[3] && addr_in[0] |=> rd_data_out[15:6] == 10'h000)
    else $error("duty high byte too wide");
  chk_duty_lo_bits: assert property (rd_in && addr_in[3] && !addr_in[0] |=> rd_data_out[15:8] == 8'h00)
    else $error("duty low byte too wide");
  chk_status_width: assert property (rd_in && addr_in == 4'h5 |=> rd_data_out[15:14] == 2'h0)
    else $error("status count too wide");
  chk_phase_step: assert property ((rd_in && addr_in == 4'h5) [*2] |=>
    rd_data_out[13:12] == $past(rd_data_out[13:12]) + 2'h1)
    else $error("phase clock did not advance");
  chk_event_pulse: assert property (period_event_out |=> !period_event_out)
    else $error("period event longer than one cycle");
endmodule

bind dcc_compare dcc_compare_chk u_chk (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .pwm_hi_out(pwm_hi_out), .pwm_lo_out(pwm_lo_out), .period_event_out(period_event_out));

// ===== verification/dcc_compare_tb.sv
module dcc_compare_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, guard = 0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wr_data_in = 16'h0000;
  wire [15:0] rd_data_out;
  wire [3:0] hi, lo;
  wire ev, fault;
  int fails = 0, n_tests = 0, hc[4], lc[4], evc;
  logic [13:0] dt[8] = '{14'h1, 14'h2, 14'h3, 14'h4, 14'h5, 14'h0, 14'h11, 14'h3FFF};
  dcc_compare DUT (.mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .pwm_hi_out(hi), .pwm_lo_out(lo),
    .period_event_out(ev));
  dcc_switch_model PWR (.mclk_in(mclk_in), .nrst_in(nrst_in), .hi_in(hi), .lo_in(lo), .guard_in(guard),
    .fault_out(fault));
  initial forever #5 mclk_in = ~mclk_in;
  // ----
  // bus and compare tasks
  // ----
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chkn(input int got, input int exp);
    chk(16'(got), 16'(exp));
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(rd_data_out, exp);
  endtask
  // junk in the unused upper bits must be dropped
  task setd(input int n, input logic [13:0] d);
    wr(4'(8 + 2 * n), {8'hFF, d[7:0]});
    wr(4'(9 + 2 * n), {10'h3FF, d[13:8]});
  endtask
  // window spans whole periods, so phase alignment does not matter
  task meas(input int n);
    hc = '{0, 0, 0, 0};
    lc = '{0, 0, 0, 0};
    evc = 0;
    repeat (n) begin
      @(posedge mclk_in);
      #1;
      chk({7'h00, hi ^ hi, lo ^ lo, ev ^ ev}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
        hc[i] += hi[i];
        lc[i] += lo[i];
      end
      evc += ev;
    end
  endtask
  task test_done;
    $display("tests=%0d fails=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #300000;
    fails++;
    test_done;
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rd(4'h1, 16'h0FFF);
    rd(4'h8, 16'h0000);
    rd(4'h6, 16'h0000);
    rd(4'h7, 16'h0000);
    wr(4'h1, 16'h0003);
    wr(4'h0, 16'h0001);
    for (int r = 0; r < 2; r++) begin
      for (int n = 0; n < 4; n++) setd(n, dt[4 * r + n]);
      repeat (40) @(posedge mclk_in);
      meas(16);
      for (int n = 0; n < 4; n++) begin
        logic [13:0] d;
        d = dt[4 * r + n];
        chkn(hc[n], d < 16 ? d : 16);
        chkn(lc[n], d < 16 ? d : 16);
        rd(4'(8 + 2 * n), {8'h00, d[7:0]});
        rd(4'(9 + 2 * n), {10'h000, d[13:8]});
      end
      chkn(evc, 1);
    end
    wr(4'h0, 16'h0101);
    setd(0, 14'h6);
    repeat (40) @(posedge mclk_in);
    meas(16);
    chkn(hc[0], 5);
    wr(4'h0, 16'h0001);
    repeat (40) @(posedge mclk_in);
    meas(16);
    chkn(hc[0], 6);
    wr(4'h2, 16'h0002);
    wr(4'h0, 16'h0081);
    repeat (40) @(posedge mclk_in);
    guard <= 1'b1;
    meas(16);
    chkn(hc[0], 4);
    chkn(lc[0], 8);
    chkn(lc[1], 16);
    guard <= 1'b0;
    wr(4'h0, 16'h0009);
    wr(4'h3, 16'h0003);
    wr(4'h4, 16'h0001);
    repeat (4) @(posedge mclk_in);
    meas(32);
    chkn(hc[0], 32);
    chkn(lc[0], 0);
    chkn(evc, 1);
    // period stays 3: a smaller one below the live count would run to full scale
    wr(4'h3, 16'h0000);
    wr(4'h0, 16'h0003);
    setd(1, 14'h5);
    setd(2, 14'h4);
    repeat (80) @(posedge mclk_in);
    meas(64);
    for (int n = 0; n < 3; n++) chkn(hc[n], 16);
    chkn(hc[3], 64);
    @(posedge mclk_in);
    addr_in <= 4'h5;
    rd_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rd_in <= 1'b0;
    // let the phase step check see its consequent before the run ends
    repeat (2) @(posedge mclk_in);
    chk({15'h0000, fault}, 16'h0000);
    test_done;
  end
endmodule

// ===== verification/dcc_switch_model.sv
module dcc_switch_model (
  input wire mclk_in, // clock
  input wire nrst_in, // reset, active low
  input wire [3:0] hi_in, // high side gates
  input wire [3:0] lo_in, // low side gates
  input wire guard_in, // complementary drive expected
  output logic fault_out // sticky shoot-through flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // a leg with both switches on shorts the supply
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) fault_out <= 1'b0;
    else if (guard_in && |(hi_in & lo_in)) fault_out <= 1'b1;
  end
endmodule

// ===== verilog/dcc_compare.v
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "dcc_map.vh"

module dcc_compare (
  input wire mclk_in, // 100 MHz system clock
  input wire nrst_in, // async reset, active low
  input wire [3:0] addr_in, // register word address
  input wire [15:0] wr_data_in, // write data
  input wire wr_in, // write strobe
  input wire rd_in, // read strobe
  output reg [15:0] rd_data_out, // read data, one cycle after rd_in
  output wire [3:0] pwm_hi_out, // high side drive per pair
  output wire [3:0] pwm_lo_out, // low side drive per pair
  output reg period_event_out // postscaled period pulse
);

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  reg tb_en;
  reg [1:0] timebase_prescale_select;
  reg [3:0] postscale;
  reg comp_mode;
  reg upd_dis;
  reg [11:0] period;
  reg [7:0] dead;
  reg [7:0] ovr_en;
  reg [7:0] ovr_val;
  reg [55:0] duty_hold;
  reg [55:0] duty_act;

  // ----------------------------------------
  // time base state
  // ----------------------------------------
  reg [1:0] phase;
  reg [5:0] pre_cnt;
  reg [11:0] timebase_count;
  reg [3:0] post_cnt;
  reg [3:0] pwm_raw;

  wire [5:0] pre_lim;
  wire pre_zero;
  wire tb_tick;
  wire wrap;
  wire period_start;
  wire load_act;
  wire [3:0] match;
  wire duty_sel;

  integer i;
  // read process keeps its own index
  integer j;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [5:0] dcc_pre_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: dcc_pre_limit = `DCC_PRE_LIM1;
        2'h1: dcc_pre_limit = `DCC_PRE_LIM4;
        2'h2: dcc_pre_limit = `DCC_PRE_LIM16;
        default: dcc_pre_limit = `DCC_PRE_LIM64;
      endcase
    end
  endfunction

  function dcc_match;
    input [13:0] duty;
    input [11:0] count;
    input [1:0] ph;
    input fine;
    input first_inst;
    reg [1:0] want;
    begin
      want = fine ? duty[1:0] : `DCC_PHASE_ONE;
      dcc_match = (duty[13:2] == count) && (ph == want) && first_inst;
    end
  endfunction

  // one byte lane of one pair, decoded alike
  // for writes and reads so the two cannot drift
  function dcc_duty_hit;
    input [3:0] addr;
    input [1:0] idx;
    input high;
    reg pick;
    begin
      pick = addr[`DCC_DUTY_SEL_BIT] && (addr[`DCC_DUTY_IDX_LSB +: 2] == idx);
      dcc_duty_hit = pick && (addr[`DCC_DUTY_HIGH_BIT] == high);
    end
  endfunction

  // ----------------------------------------
  // phase clocks and time base
  // ----------------------------------------
  assign pre_lim = dcc_pre_limit(timebase_prescale_select);
  assign pre_zero = (pre_cnt == 6'h00);
  assign tb_tick = tb_en && (phase == `DCC_PHASE_FOUR) && (pre_cnt == pre_lim);
  // wrap is on equality: a period written below the live count
  // lets the count run to full scale before the next wrap
  assign wrap = tb_tick && (timebase_count == period);
  assign period_start = tb_en && (phase == `DCC_PHASE_ONE) && pre_zero &&
                        (timebase_count == 12'h000);
  // new duty takes effect at a period boundary unless upd_dis is set, or at once while the time base is off, to avoid runt pulses
  assign load_act = (wrap && !upd_dis) || !tb_en;

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase <= `DCC_PHASE_ONE;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_cnt <= 6'h00;
      timebase_count <= 12'h000;
      post_cnt <= 4'h0;
      period_event_out <= 1'b0;
    end else begin
      period_event_out <= 1'b0;
      // disabling freezes the count rather than clearing it
      if (tb_en && (phase == `DCC_PHASE_FOUR)) begin
        pre_cnt <= (pre_cnt == pre_lim) ? 6'h00 : pre_cnt + 6'h01;
      end
      if (tb_tick) begin
        timebase_count <= wrap ? 12'h000 : timebase_count + 12'h001;
      end
      if (wrap) begin
        if (post_cnt == postscale) begin
          post_cnt <= 4'h0;
          period_event_out <= 1'b1;
        end else begin
          post_cnt <= post_cnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // duty compare, one unit per pair
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_ch
      assign match[g] = tb_en && dcc_match(duty_act[g*14 +: 14], timebase_count, phase,
                        timebase_prescale_select == `DCC_PRE_DIV1, pre_zero);

      always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pwm_raw[g] <= 1'b0;
        end else if (!tb_en) begin
          pwm_raw[g] <= 1'b0;
        end else if (match[g]) begin
          // match beats start so a zero duty gives no pulse
          pwm_raw[g] <= 1'b0;
        end else if (period_start) begin
          pwm_raw[g] <= 1'b1;
        end
      end

      dcc_pair_out u_pair (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .raw_in(pwm_raw[g]),
        .comp_in(comp_mode),
        .dead_in(dead),
        .ovr_en_in(ovr_en[2*g +: 2]),
        .ovr_val_in(ovr_val[2*g +: 2]),
        .hi_out(pwm_hi_out[g]),
        .lo_out(pwm_lo_out[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign duty_sel = addr_in[`DCC_DUTY_SEL_BIT];

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tb_en <= 1'b0;
      timebase_prescale_select <= 2'h0;
      postscale <= 4'h0;
      comp_mode <= 1'b0;
      upd_dis <= 1'b0;
      period <= `DCC_RST_PERIOD;
      dead <= `DCC_RST_DEAD;
      ovr_en <= `DCC_RST_OVR;
      ovr_val <= `DCC_RST_OVR;
    end else if (wr_in && !duty_sel) begin
      case (addr_in)
        `DCC_OFS_CTRL: begin
          tb_en <= wr_data_in[`DCC_CTRL_EN_BIT];
          timebase_prescale_select <= wr_data_in[`DCC_CTRL_PRE_LSB +: 2];
          postscale <= wr_data_in[`DCC_CTRL_POST_LSB +: 4];
          comp_mode <= wr_data_in[`DCC_CTRL_COMP_BIT];
          upd_dis <= wr_data_in[`DCC_CTRL_UPD_DIS_BIT];
        end
        `DCC_OFS_PERIOD: begin
          period <= wr_data_in[11:0];
        end
        `DCC_OFS_DEAD: begin
          dead <= wr_data_in[7:0];
        end
        `DCC_OFS_OVR_EN: begin
          ovr_en <= wr_data_in[7:0];
        end
        `DCC_OFS_OVR_VAL: begin
          ovr_val <= wr_data_in[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // holding and active copies of the four duty values
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      duty_hold <= {4{`DCC_RST_DUTY}};
      duty_act <= {4{`DCC_RST_DUTY}};
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_in && dcc_duty_hit(addr_in, i[1:0], 1'b1)) begin
          duty_hold[i*14+8 +: 6] <= wr_data_in[5:0];
        end
        if (wr_in && dcc_duty_hit(addr_in, i[1:0], 1'b0)) begin
          duty_hold[i*14 +: 8] <= wr_data_in[7:0];
        end
      end
      if (load_act) begin
        duty_act <= duty_hold;
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= 16'h0000;
    end else if (rd_in) begin
      rd_data_out <= 16'h0000;
      if (duty_sel) begin
        // reads return the holding copy, the one software wrote
        for (j = 0; j < 4; j = j + 1) begin
          if (dcc_duty_hit(addr_in, j[1:0], 1'b1)) begin
            rd_data_out <= {10'h000, duty_hold[j*14+8 +: 6]};
          end
          if (dcc_duty_hit(addr_in, j[1:0], 1'b0)) begin
            rd_data_out <= {8'h00, duty_hold[j*14 +: 8]};
          end
        end
      end else begin
        case (addr_in)
          `DCC_OFS_CTRL: begin
            rd_data_out <= {7'h00, upd_dis, comp_mode, postscale,
                            timebase_prescale_select, tb_en};
          end
          `DCC_OFS_PERIOD: begin
            rd_data_out <= {4'h0, period};
          end
          `DCC_OFS_DEAD: begin
            rd_data_out <= {8'h00, dead};
          end
          `DCC_OFS_OVR_EN: begin
            rd_data_out <= {8'h00, ovr_en};
          end
          `DCC_OFS_OVR_VAL: begin
            rd_data_out <= {8'h00, ovr_val};
          end
          `DCC_OFS_STATUS: begin
            rd_data_out <= {2'h0, phase, timebase_count};
          end
          default: begin
            rd_data_out <= 16'h0000;
          end
        endcase
      end
    end
  end

endmodule

// ===== verilog/dcc_map.vh
`ifndef DCC_MAP_VH
`define DCC_MAP_VH

// ----------------------------------------
// register offsets (word addresses)
// ----------------------------------------
`define DCC_OFS_CTRL 4'h0
`define DCC_OFS_PERIOD 4'h1
`define DCC_OFS_DEAD 4'h2
`define DCC_OFS_OVR_EN 4'h3
`define DCC_OFS_OVR_VAL 4'h4
`define DCC_OFS_STATUS 4'h5
// duty bytes live at 8..F: bit 3 set, bits 2:1 pair, bit 0 high byte
`define DCC_DUTY_SEL_BIT 3
`define DCC_DUTY_IDX_LSB 1
`define DCC_DUTY_HIGH_BIT 0

// ----------------------------------------
// control register fields
// ----------------------------------------
`define DCC_CTRL_EN_BIT 0
`define DCC_CTRL_PRE_LSB 1
`define DCC_CTRL_POST_LSB 3
`define DCC_CTRL_COMP_BIT 7
`define DCC_CTRL_UPD_DIS_BIT 8

// ----------------------------------------
// status register fields
// ----------------------------------------
`define DCC_STAT_COUNT_LSB 0
`define DCC_STAT_PHASE_LSB 12

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCC_RST_PERIOD 12'hFFF
`define DCC_RST_DEAD 8'h00
`define DCC_RST_DUTY 14'h0000
`define DCC_RST_OVR 8'h00

// ----------------------------------------
// phase clocks and prescale limits
// ----------------------------------------
`define DCC_PHASE_ONE 2'h0
`define DCC_PHASE_FOUR 2'h3
`define DCC_PRE_DIV1 2'h0
`define DCC_PRE_LIM1 6'h00
`define DCC_PRE_LIM4 6'h03
`define DCC_PRE_LIM16 6'h0F
`define DCC_PRE_LIM64 6'h3F

`endif

// ===== verilog/dcc_pair_out.v
`include "dcc_map.vh"

module dcc_pair_out (
  input wire mclk_in, // system clock
  input wire nrst_in, // async reset, active low
  input wire raw_in, // compare result for this pair
  input wire comp_in, // complementary mode
  input wire [7:0] dead_in, // dead time in clock cycles
  input wire [1:0] ovr_en_in, // force enable, bit 0 high side
  input wire [1:0] ovr_val_in, // forced level, bit 0 high side
  output reg hi_out, // high side switch drive
  output reg lo_out // low side switch drive
);

  reg raw_d;
  reg [7:0] dt_cnt;
  reg blank;
  reg next_hi;
  reg next_lo;

  // ----------------------------------------
  // dead time counter
  // ----------------------------------------
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      raw_d <= 1'b0;
      dt_cnt <= 8'h00;
    end else begin
      raw_d <= raw_in;
      if (raw_in != raw_d) begin
        // edge cycle itself blanks once, so load one less
        dt_cnt <= (dead_in != 8'h00) ? dead_in - 8'h01 : 8'h00;
      end else if (dt_cnt != 8'h00) begin
        dt_cnt <= dt_cnt - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // output select and override
  // ----------------------------------------
  always @* begin
    blank = (raw_in != raw_d) ? (dead_in != 8'h00) : (dt_cnt != 8'h00);
    if (comp_in) begin
      next_hi = raw_in & ~blank;
      next_lo = ~raw_in & ~blank;
    end else begin
      next_hi = raw_in;
      next_lo = raw_in;
    end
    // override sits last so a forced level wins over dead time
    if (ovr_en_in[0]) begin
      next_hi = ovr_val_in[0];
    end
    if (ovr_en_in[1]) begin
      next_lo = ovr_val_in[1];
    end
  end

  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hi_out <= 1'b0;
      lo_out <= 1'b0;
    end else begin
      hi_out <= next_hi;
      lo_out <= next_lo;
    end
  end

endmodule
